/* cou_pkg.sv */
// Operation
// RULE_01 - enable bit 7 of main control turns the generator on; cleared keeps it off
// RULE_02 - load request bit 6 schedules count-to-buffer transfer at next input events; when enabled, code transfers only at an event on a generator tick
// RULE_03 - hardware clears load request when the transfer is done
// RULE_04 - main bit 5 and polarity bits 5:4 ignore writes and read zero
// RULE_05 - clock select: 10 fast oscillator, 01 system clock, 00 system clock/4
// RULE_06 - software must not write reserved clock select code 11
// RULE_07 - mode 101 push-pull pair, mode 100 half-bridge pair
// RULE_08 - mode 011 reverse full bridge, mode 010 forward full bridge
// RULE_09 - mode 001 synchronous steered output, mode 000 plain steered output
// RULE_10 - software must not write reserved mode codes 11x
// RULE_11 - rise dead-band source set uses delay chain, cleared uses clock counts
// RULE_12 - fall dead-band source set uses delay chain, cleared uses clock counts
// RULE_13 - polarity bits 3..0 for outputs D..A make active level low when set
// RULE_14 - each rising source enable bit admits its source; cleared source ignored
// RULE_15 - rising sources bit7 numeric osc down to bit0 remapped pin
// RULE_16 - all implemented control bits clear to zero on every reset
// RULE_17 - while disabled, count writes load working buffers directly
// RULE_18 - while enabled, buffers update together only after load request
// RULE_19 - any enabled rising source alone can produce a rising event
package cou_pkg;
    localparam logic [7:0] ADDR_MAIN     = 8'h00;
    localparam logic [7:0] ADDR_DBPOL    = 8'h04;
    localparam logic [7:0] ADDR_RISE     = 8'h08;
    localparam logic [7:0] ADDR_RISE_DB  = 8'h0C;
    localparam logic [7:0] ADDR_FALL_DB  = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam int         BIT_EN        = 7;
    localparam int         BIT_LD        = 6;
    localparam int         CS_LSB        = 3;
    localparam int         BIT_RDBS      = 7;
    localparam int         BIT_FDBS      = 6;
    localparam logic [7:0] MAIN_WMASK    = 8'hDF;
    localparam logic [7:0] DBPOL_WMASK   = 8'hCF;
    localparam logic [7:0] RESET_VAL     = 8'h00;
    localparam logic [1:0] CS_FOSC4      = 2'h0;
    localparam logic [1:0] CS_FOSC       = 2'h1;
    localparam logic [1:0] CS_FAST       = 2'h2;
    localparam logic [1:0] DIV4_LAST     = 2'h3;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    typedef enum logic [2:0] {
        COU_MD_STEER      = 3'b000,
        COU_MD_SYNC_STEER = 3'b001,
        COU_MD_FWD_FULL   = 3'b010,
        COU_MD_REV_FULL   = 3'b011,
        COU_MD_HALF       = 3'b100,
        COU_MD_PUSH_PULL  = 3'b101
    } cou_mode_t;
    typedef enum logic [1:0] {
        COU_LD_IDLE = 2'b00,
        COU_LD_WAIT = 2'b01,
        COU_LD_COPY = 2'b10
    } cou_ld_state_t;
endpackage

/* cou_clk_sel.sv */
`timescale 1ns/1ps
module cou_clk_sel
    import cou_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       en_i,
    input  wire logic [1:0] sel_i,
    input  wire logic       fast_tick_i,
    output logic            tick_o
);
    logic [1:0] div_cnt;
    wire        div_wrap = (div_cnt == DIV4_LAST);
    wire        next_tick = en_i && ((sel_i == CS_FOSC) ||                 // [RULE_05]
                                     (sel_i == CS_FOSC4 && div_wrap) ||
                                     (sel_i == CS_FAST && fast_tick_i));
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 2'h0;
            tick_o  <= 1'b0;
        end else begin
            div_cnt <= en_i ? div_cnt + 2'h1 : 2'h0;
            tick_o  <= next_tick;
        end
    end
endmodule

/* cou_rise_sel.sv */
`timescale 1ns/1ps
module cou_rise_sel
    import cou_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] src_i,  // 7 osc, 6 modulator, 5:4 capture-compare, 3 logic cell, 2:1 comps, 0 pin [RULE_15]
    input  wire logic [7:0] en_i,
    output logic            rise_o
);
    logic [7:0] gated;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_src
            assign gated[g] = src_i[g] & en_i[g];                       // [RULE_14]
        end
    endgenerate
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rise_o <= 1'b0;
        else rise_o <= |gated;                                          // [RULE_19]
    end
endmodule

/* cou_ctrl_regs.sv */
`timescale 1ns/1ps
module cou_ctrl_regs
    import cou_pkg::*;
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic [7:0] S_AXI_AWADDR_I,
    input  wire logic       S_AXI_AWVALID_I,
    output logic            S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0] S_AXI_WSTRB_I,
    input  wire logic       S_AXI_WVALID_I,
    output logic            S_AXI_WREADY_O,
    output logic [1:0]      S_AXI_BRESP_O,
    output logic            S_AXI_BVALID_O,
    input  wire logic       S_AXI_BREADY_I,
    input  wire logic [7:0] S_AXI_ARADDR_I,
    input  wire logic       S_AXI_ARVALID_I,
    output logic            S_AXI_ARREADY_O,
    output logic [31:0]     S_AXI_RDATA_O,
    output logic [1:0]      S_AXI_RRESP_O,
    output logic            S_AXI_RVALID_O,
    input  wire logic       S_AXI_RREADY_I,
    input  wire logic       FAST_OSC_TICK_I,
    input  wire logic [7:0] RISE_SRC_I,
    input  wire logic       FALL_EVENT_I,
    output logic            MODULE_ON_O,
    output logic            GEN_CLK_TICK_O,
    output logic            RISE_EVENT_O,
    output logic [2:0]      OUTPUT_MODE_O,
    output logic            RISE_DB_CHAIN_O,
    output logic            FALL_DB_CHAIN_O,
    output logic [3:0]      OUT_POLARITY_O,
    output logic            FAST_OSC_KEEP_O,
    output logic [7:0]      RISE_DB_BUF_O,
    output logic [7:0]      FALL_DB_BUF_O
);
    logic [7:0]    main_reg;
    logic [7:0]    dbpol_reg;
    logic [7:0]    rise_en;
    logic [7:0]    rise_db;
    logic [7:0]    fall_db;
    logic          aw_held;
    logic          w_held;
    logic [7:0]    aw_addr;
    logic [7:0]    w_data;
    logic          w_lane0;
    cou_ld_state_t ld_state;
    logic          gen_tick;
    logic          rise_ev;

    // write address and data captured separately, either order
    wire        aw_take   = S_AXI_AWVALID_I && !aw_held;
    wire        w_take    = S_AXI_WVALID_I && !w_held;
    wire        wr_go     = aw_held && w_held && !S_AXI_BVALID_O;
    wire        wr_lane   = wr_go && w_lane0;
    wire        wr_main   = wr_lane && (aw_addr == ADDR_MAIN);
    wire        wr_dbpol  = wr_lane && (aw_addr == ADDR_DBPOL);
    wire        wr_rise   = wr_lane && (aw_addr == ADDR_RISE);
    wire        wr_rdb    = wr_lane && (aw_addr == ADDR_RISE_DB);
    wire        wr_fdb    = wr_lane && (aw_addr == ADDR_FALL_DB);
    wire        wr_hit    = (aw_addr == ADDR_MAIN) || (aw_addr == ADDR_DBPOL) ||
                            (aw_addr == ADDR_RISE) || (aw_addr == ADDR_RISE_DB) ||
                            (aw_addr == ADDR_FALL_DB) || (aw_addr == ADDR_STATUS);
    wire        rd_go     = S_AXI_ARVALID_I && !S_AXI_RVALID_O;
    wire        module_on = main_reg[BIT_EN];                           // [RULE_01]
    // both event kinds count as "input events" for the transfer point
    wire        in_event  = rise_ev || FALL_EVENT_I;
    wire        ld_done   = (ld_state == COU_LD_COPY);
    wire        ld_req_wr = wr_main && w_data[BIT_LD];
    wire        direct_ld = !module_on;                                 // [RULE_17]
    wire [7:0]  status    = {6'h00, ld_state};
    wire [7:0]  next_main = (main_reg & ~MAIN_WMASK) | (w_data & MAIN_WMASK);
    wire [7:0]  rd_byte;
    wire        rd_hit;

    assign rd_hit  = (S_AXI_ARADDR_I == ADDR_MAIN) || (S_AXI_ARADDR_I == ADDR_DBPOL) ||
                     (S_AXI_ARADDR_I == ADDR_RISE) || (S_AXI_ARADDR_I == ADDR_RISE_DB) ||
                     (S_AXI_ARADDR_I == ADDR_FALL_DB) || (S_AXI_ARADDR_I == ADDR_STATUS);
    assign rd_byte = (S_AXI_ARADDR_I == ADDR_MAIN)    ? (main_reg & MAIN_WMASK) :   // [RULE_04]
                     (S_AXI_ARADDR_I == ADDR_DBPOL)   ? (dbpol_reg & DBPOL_WMASK) :
                     (S_AXI_ARADDR_I == ADDR_RISE)    ? rise_en :
                     (S_AXI_ARADDR_I == ADDR_RISE_DB) ? rise_db :
                     (S_AXI_ARADDR_I == ADDR_FALL_DB) ? fall_db :
                     (S_AXI_ARADDR_I == ADDR_STATUS)  ? status : 8'h00;

    cou_clk_sel u_clk (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (RST_N_I),
        .en_i        (module_on),
        .sel_i       (main_reg[CS_LSB+1:CS_LSB]),
        .fast_tick_i (FAST_OSC_TICK_I),
        .tick_o      (gen_tick)
    );

    cou_rise_sel u_rise (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .src_i   (RISE_SRC_I),
        .en_i    (rise_en),
        .rise_o  (rise_ev)
    );

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O  <= 1'b1;
            aw_addr         <= 8'h00;
            w_data          <= 8'h00;
            w_lane0         <= 1'b0;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                S_AXI_AWREADY_O <= 1'b0;
                aw_addr <= {S_AXI_AWADDR_I[7:2], 2'h0};
            end
            if (w_take) begin
                w_held  <= 1'b1;
                S_AXI_WREADY_O <= 1'b0;
                w_data  <= S_AXI_WDATA_I[7:0];
                w_lane0 <= S_AXI_WSTRB_I[0];
            end
            if (wr_go) begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                // readies mirror the holds as flops, so no port is combinational
                S_AXI_AWREADY_O <= 1'b1;
                S_AXI_WREADY_O  <= 1'b1;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RDATA_O  <= 32'h0000_0000;
            S_AXI_RRESP_O  <= RESP_OKAY;
        end else if (rd_go) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RDATA_O  <= {24'h000000, rd_byte};
            S_AXI_RRESP_O  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_ARREADY_O <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            main_reg  <= RESET_VAL;                                     // [RULE_16]
            dbpol_reg <= RESET_VAL;
            rise_en   <= RESET_VAL;
        end else begin
            if (wr_main) main_reg <= next_main;
            else if (ld_done) main_reg[BIT_LD] <= 1'b0;                 // [RULE_03]
            if (wr_dbpol) dbpol_reg <= w_data & DBPOL_WMASK;            // [RULE_04]
            if (wr_rise) rise_en <= w_data;
        end
    end

    // load handshake: a write wins over a same-cycle completion
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ld_state <= COU_LD_IDLE;
        end else begin
            case (ld_state)
                COU_LD_IDLE: if (ld_req_wr) ld_state <= direct_ld ? COU_LD_COPY : COU_LD_WAIT;
                COU_LD_WAIT: if (!module_on || (in_event && gen_tick)) ld_state <= COU_LD_COPY;  // [RULE_02] [RULE_18]
                COU_LD_COPY: ld_state <= ld_req_wr ? COU_LD_WAIT : COU_LD_IDLE;
                default:     ld_state <= COU_LD_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rise_db       <= RESET_VAL;
            fall_db       <= RESET_VAL;
            RISE_DB_BUF_O <= RESET_VAL;
            FALL_DB_BUF_O <= RESET_VAL;
        end else begin
            if (wr_rdb) rise_db <= w_data;
            if (wr_fdb) fall_db <= w_data;
            if (direct_ld) begin                                        // [RULE_17]
                RISE_DB_BUF_O <= wr_rdb ? w_data : rise_db;
                FALL_DB_BUF_O <= wr_fdb ? w_data : fall_db;
            end else if (ld_done) begin                                 // [RULE_18]
                RISE_DB_BUF_O <= rise_db;
                FALL_DB_BUF_O <= fall_db;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            MODULE_ON_O     <= 1'b0;
            GEN_CLK_TICK_O  <= 1'b0;
            RISE_EVENT_O    <= 1'b0;
            OUTPUT_MODE_O   <= COU_MD_STEER;
            RISE_DB_CHAIN_O <= 1'b0;
            FALL_DB_CHAIN_O <= 1'b0;
            OUT_POLARITY_O  <= 4'h0;
            FAST_OSC_KEEP_O <= 1'b0;
        end else begin
            MODULE_ON_O     <= module_on;                               // [RULE_01]
            GEN_CLK_TICK_O  <= gen_tick;
            RISE_EVENT_O    <= rise_ev && module_on;                    // [RULE_19]
            OUTPUT_MODE_O   <= main_reg[2:0];                           // [RULE_07] [RULE_08] [RULE_09]
            RISE_DB_CHAIN_O <= dbpol_reg[BIT_RDBS];                     // [RULE_11]
            FALL_DB_CHAIN_O <= dbpol_reg[BIT_FDBS];                     // [RULE_12]
            OUT_POLARITY_O  <= dbpol_reg[3:0];                          // [RULE_13]
            FAST_OSC_KEEP_O <= module_on && (main_reg[CS_LSB+1:CS_LSB] == CS_FAST);  // [RULE_05]
        end
    end

    property p_ld_clears;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ld_done |=> !main_reg[BIT_LD] || $past(ld_req_wr);
    endproperty
    a_ld_clears: assert property (p_ld_clears) else $error("load request not cleared"); // [RULE_03]

    property p_reserved_zero;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !main_reg[5] && (dbpol_reg[5:4] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // [RULE_04]

    property p_on_follows;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        wr_main |=> ##1 (MODULE_ON_O == $past(w_data[BIT_EN], 2));
    endproperty
    a_on_follows: assert property (p_on_follows) else $error("enable output wrong"); // [RULE_01]

    property p_wait_enabled;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (ld_state == COU_LD_WAIT && module_on && !(in_event && gen_tick)) |=> ld_state == COU_LD_WAIT;
    endproperty
    a_wait_enabled: assert property (p_wait_enabled) else $error("transfer too early"); // [RULE_02]

    property p_buf_hold;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (module_on && !ld_done) |=> $stable(RISE_DB_BUF_O) && $stable(FALL_DB_BUF_O);
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("buffer moved without load"); // [RULE_18]

    property p_direct;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (wr_rdb && direct_ld) |=> RISE_DB_BUF_O == rise_db;
    endproperty
    a_direct: assert property (p_direct) else $error("disabled write not loaded"); // [RULE_17]

    sequence s_rise_armed;
        (|(RISE_SRC_I & rise_en)) && module_on;
    endsequence
    property p_rise_any;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        s_rise_armed ##1 module_on |=> RISE_EVENT_O;
    endproperty
    a_rise_any: assert property (p_rise_any) else $error("rising event missed"); // [RULE_19]

    property p_rise_masked;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ((RISE_SRC_I & ~rise_en) != 8'h00) && ((RISE_SRC_I & rise_en) == 8'h00) |=> !rise_ev;
    endproperty
    a_rise_masked: assert property (p_rise_masked) else $error("disabled source leaked"); // [RULE_14]

    property p_pol;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        wr_dbpol |=> ##1 (OUT_POLARITY_O == $past(w_data[3:0], 2));
    endproperty
    a_pol: assert property (p_pol) else $error("polarity output wrong"); // [RULE_13]

    property p_tick_fosc;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (module_on && (main_reg[CS_LSB+1:CS_LSB] == CS_FOSC)) |=> gen_tick;
    endproperty
    a_tick_fosc: assert property (p_tick_fosc) else $error("system clock tick missing"); // [RULE_05]

    property p_off_quiet;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !module_on |=> !gen_tick;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("tick while disabled"); // [RULE_01]

    property p_fast_keep;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (module_on && (main_reg[CS_LSB+1:CS_LSB] == CS_FAST)) |=> FAST_OSC_KEEP_O;
    endproperty
    a_fast_keep: assert property (p_fast_keep) else $error("fast oscillator not kept"); // [RULE_05]

    property p_mode_follows;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        wr_main |=> ##1 (OUTPUT_MODE_O == $past(w_data[2:0], 2));
    endproperty
    a_mode_follows: assert property (p_mode_follows) else $error("mode output wrong"); // [RULE_07]
endmodule

/* cou_far_model.sv */
`timescale 1ns/1ps
// event and oscillator sources feeding the generator; oscillator runs free, as a real one does
module cou_far_model
    import cou_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] rise_req_i,
    input  wire logic       fall_req_i,
    output logic            fast_tick_o,
    output logic [7:0]      rise_src_o,
    output logic            fall_evt_o
);
    logic [1:0] div;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div         <= 2'h0;
            fast_tick_o <= 1'b0;
            rise_src_o  <= 8'h00;
            fall_evt_o  <= 1'b0;
        end else begin
            div         <= (div == 2'h2) ? 2'h0 : div + 2'h1;
            fast_tick_o <= (div == 2'h2);
            rise_src_o  <= rise_req_i;
            fall_evt_o  <= fall_req_i;
        end
    end
endmodule

/* complementary_output_control_regs_bench.sv */
`timescale 1ns/1ps
module complementary_output_control_regs_bench
    import cou_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rise_req = 8'h00, rise_src, rbuf, fbuf;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        fall_req = 1'b0, fast_tick, fall_evt;
    logic [3:0]  wstrb = 4'h1;
    logic        awready, wready, bvalid, arready, rvalid, mod_on, gtick, rise_evt, db_r, db_f, keep;
    logic [1:0]  bresp, rresp;
    logic [2:0]  mode;
    logic [3:0]  pol;
    int          err_total = 0;
    int          comparisons = 0;

    always #10 clk = ~clk;

    cou_ctrl_regs cou_ctrl_regs_inst (
        .CORE_CLK_I(clk), .RST_N_I(rst_n),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .FAST_OSC_TICK_I(fast_tick), .RISE_SRC_I(rise_src), .FALL_EVENT_I(fall_evt),
        .MODULE_ON_O(mod_on), .GEN_CLK_TICK_O(gtick), .RISE_EVENT_O(rise_evt), .OUTPUT_MODE_O(mode),
        .RISE_DB_CHAIN_O(db_r), .FALL_DB_CHAIN_O(db_f), .OUT_POLARITY_O(pol),
        .FAST_OSC_KEEP_O(keep), .RISE_DB_BUF_O(rbuf), .FALL_DB_BUF_O(fbuf)
    );

    cou_far_model cou_far_model_inst (
        .clk_i(clk), .rst_n_i(rst_n), .rise_req_i(rise_req), .fall_req_i(fall_req),
        .fast_tick_o(fast_tick), .rise_src_o(rise_src), .fall_evt_o(fall_evt)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // handshakes are judged at the negedge; inputs and registers only move on the rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        int n;
        logic aw_ok, w_ok, b_ok;
        logic [1:0] r;
        n = 0;
        b_ok = 1'b0;
        r = 2'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_ok && n < 50) begin
            @(negedge clk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        chk(b_ok, 1'b1);
        chk(r, exp);
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r);
        int n;
        logic ar_ok, ok;
        logic [31:0] d;
        logic [1:0] r;
        n = 0;
        ok = 1'b0;
        d = 32'h0;
        r = 2'h0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!ok && n < 50) begin
            @(negedge clk);
            ar_ok = arvalid && arready;
            ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_ok) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        chk(ok, 1'b1);
        chk(d, exp);
        chk(r, exp_r);
        @(posedge clk);
    endtask

    task automatic ticks(input logic [31:0] exp);
        int n;
        n = 0;
        repeat (12) begin
            @(negedge clk);
            if (gtick === 1'b1) n++;
        end
        @(posedge clk);
        chk(n, exp);
    endtask

    task automatic done(input string name);
        $display("test %s finished, %0d mismatches so far", name, err_total);
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        cyc(10);
        rst_n <= 1'b1;
        cyc(1);
        rd(ADDR_MAIN, 32'h0, RESP_OKAY);
        rd(ADDR_DBPOL, 32'h0, RESP_OKAY);
        rd(ADDR_RISE, 32'h0, RESP_OKAY);
        rd(8'h18, 32'h0, RESP_SLVERR);
        wr(8'h1C, 32'hFF, RESP_SLVERR);
        // lane 0 strobe low: the write is answered but must not land
        wstrb <= 4'h0;
        wr(ADDR_RISE, 32'hFF, RESP_OKAY);
        wstrb <= 4'h1;
        rd(ADDR_RISE, 32'h0, RESP_OKAY);
        done("reset");
        wr(ADDR_MAIN, 32'h2D, RESP_OKAY);
        rd(ADDR_MAIN, 32'h0D, RESP_OKAY);
        wr(ADDR_DBPOL, 32'hFF, RESP_OKAY);
        rd(ADDR_DBPOL, 32'hCF, RESP_OKAY);
        chk({db_r, db_f, pol}, 6'h3F);
        wr(ADDR_DBPOL, 32'h45, RESP_OKAY);
        chk({db_r, db_f, pol}, 6'h15);
        // modes 11x and clock code 11 are never written
        for (int m = 0; m < 6; m++) begin
            wr(ADDR_MAIN, 32'h08 | m, RESP_OKAY);
            cyc(2);
            chk(mode, m);
        end
        done("fields");
        wr(ADDR_RISE_DB, 32'h5A, RESP_OKAY);
        wr(ADDR_FALL_DB, 32'hA5, RESP_OKAY);
        cyc(2);
        chk({rbuf, fbuf}, 16'h5AA5);
        wr(ADDR_MAIN, 32'h88, RESP_OKAY);
        wr(ADDR_RISE_DB, 32'h33, RESP_OKAY);
        wr(ADDR_FALL_DB, 32'h44, RESP_OKAY);
        wr(ADDR_MAIN, 32'hC8, RESP_OKAY);
        cyc(3);
        chk({rbuf, fbuf}, 16'h5AA5);
        rd(ADDR_MAIN, 32'hC8, RESP_OKAY);
        rd(ADDR_STATUS, 32'h1, RESP_OKAY);
        fall_req <= 1'b1;
        cyc(6);
        chk({rbuf, fbuf}, 16'h3344);
        rd(ADDR_MAIN, 32'h88, RESP_OKAY);
        fall_req <= 1'b0;
        done("buffers");
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_RISE, 32'h1 << i, RESP_OKAY);
            rise_req <= 8'h01 << i;
            cyc(5);
            chk(rise_evt, 1'b1);
            wr(ADDR_RISE, ~(32'h1 << i) & 32'hFF, RESP_OKAY);
            cyc(5);
            chk(rise_evt, 1'b0);
        end
        wr(ADDR_RISE, 32'hFF, RESP_OKAY);
        cyc(5);
        chk(rise_evt, 1'b1);
        rd(ADDR_RISE, 32'hFF, RESP_OKAY);
        rise_req <= 8'h00;
        done("rise");
        cyc(4);
        ticks(32'd12);
        wr(ADDR_MAIN, 32'h80, RESP_OKAY);
        cyc(4);
        ticks(32'd3);
        wr(ADDR_MAIN, 32'h90, RESP_OKAY);
        cyc(4);
        ticks(32'd4);
        chk({mod_on, keep}, 2'h3);
        wr(ADDR_MAIN, 32'h10, RESP_OKAY);
        cyc(4);
        ticks(32'd0);
        chk({mod_on, keep}, 2'h0);
        done("clock");
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        rd(ADDR_MAIN, 32'h0, RESP_OKAY);
        rd(ADDR_DBPOL, 32'h0, RESP_OKAY);
        rd(ADDR_RISE, 32'h0, RESP_OKAY);
        done("second reset");
        complete_run;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run;
    end
endmodule
